// [verilog/bms_pkg.sv]
/*
 * Shared constants, types and helpers of the boot mode sequencer.
 * Assumes that every user writes bms_pkg::name and never imports it.
 */
package bms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Boot image and address constants.
  localparam int          BOOT_BYTES     = 1024;
  localparam int          BOOT_WORDS     = BOOT_BYTES / 4;
  localparam int          WORD_BYTES     = 4;
  localparam logic [31:0] CPU_START_ADDR = 32'h0000_0000;
  localparam logic [31:0] BOOT_DEST_ADDR = 32'h0000_0000;
  localparam logic [31:0] BOOT_ROM_BASE  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Strap encodings.
  localparam logic [1:0] MODE_HOST  = 2'h0;
  localparam logic [1:0] MODE_EMU   = 2'h1;
  localparam logic [1:0] MODE_EXTERNAL_MEMORY_INTERFACE  = 2'h2;
  localparam logic [1:0] WIDTH_8    = 2'h0;
  localparam logic [1:0] WIDTH_16   = 2'h1;
  localparam logic [1:0] WIDTH_32   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [4:0] {
    ST_RESET     = 5'h01,
    ST_HOST_WAIT = 5'h02,
    ST_COPY_RD   = 5'h04,
    ST_COPY_WR   = 5'h08,
    ST_RUN       = 5'h10
  } bms_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] width;
    logic       big_endian;
  } bms_straps_s;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } bms_rom_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } bms_mem_wr_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bytes delivered by one ROM read for a given ROM width.
  function automatic logic [2:0] bms_lane_bytes(input logic [1:0] width);
    logic [2:0] n;
    n = 3'h4;
    if (width == WIDTH_8) begin
      n = 3'h1;
    end else if (width == WIDTH_16) begin
      n = 3'h2;
    end
    return n;
  endfunction

endpackage

// [verilog/bms_word_packer.sv]
/*
 * Packs 8-bit or 16-bit ROM reads into 32-bit instruction words.
 * Assumes narrow ROM data sits in the low bits of i_data and that the
 * width and byte order stay fixed while a boot copy runs.
 */
`timescale 1ns/100ps
module bms_word_packer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic [1:0]  i_width,
  input  wire logic        i_big_endian,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_data,
  output logic             o_word_valid,
  output logic [31:0]      o_word
);

  logic [31:0] acc_reg;
  logic [2:0]  fill_reg;
  logic [2:0]  bytes;
  logic [31:0] lane;
  logic [31:0] acc_next;

  always_comb begin
    bytes = bms_pkg::bms_lane_bytes(i_width);
    lane  = i_data;
    if (bytes == 3'h1) begin
      lane = {24'h00_0000, i_data[7:0]};
    end else if (bytes == 3'h2) begin
      lane = {16'h0000, i_data[15:0]};
    end
    // Big-endian images hold the first byte in the most significant lane.
    if (i_big_endian) begin
      acc_next = (acc_reg << {bytes, 3'h0}) | lane;
    end else begin
      acc_next = acc_reg | (lane << {fill_reg, 3'h0});
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg      <= 32'h0000_0000;
      fill_reg     <= 3'h0;
      o_word_valid <= 1'b0;
      o_word       <= 32'h0000_0000;
    end else begin
      o_word_valid <= 1'b0;
      if (i_valid) begin
        if (fill_reg + bytes == 3'h4) begin
          o_word_valid <= 1'b1;
          o_word       <= acc_next;
          acc_reg      <= 32'h0000_0000;
          fill_reg     <= 3'h0;
        end else begin
          acc_reg  <= acc_next;
          fill_reg <= fill_reg + bytes;
        end
      end
    end
  end

endmodule

// [verilog/bms_boot_sequencer.sv]
/*
 * Reset and boot sequencing: internal reset, CPU stall, host and
 * emulation release, and the boot ROM copy to the start of memory.
 * Assumes a synchronous ROM read port, a memory write port with ready,
 * and host-port strobes for setting and clearing the host interrupt bit.
 */
`timescale 1ns/100ps
module bms_boot_sequencer #(
  parameter logic [31:0] ROM_BASE = bms_pkg::BOOT_ROM_BASE
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic [1:0]            i_boot_mode,
  input  wire logic [1:0]            i_rom_width,
  input  wire logic                  i_big_endian,
  input  wire logic                  i_hostint_set,
  input  wire logic                  i_hostint_clear,
  input  wire logic                  i_rom_ack,
  input  wire logic [31:0]           i_rom_data,
  input  wire logic                  i_mem_wr_ready,
  output logic                       o_int_resetn,
  output logic                       o_cpu_stall,
  output logic                       o_cpu_start,
  output logic [31:0]                o_cpu_start_addr,
  output logic                       o_host_mem_en,
  output logic                       o_hostint_bit,
  output logic                       o_cpu_hostint,
  output bms_pkg::bms_straps_s       o_straps,
  output bms_pkg::bms_rom_req_s      o_rom_rd,
  output bms_pkg::bms_mem_wr_s       o_mem_wr
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  bms_pkg::bms_state_e state_reg;
  logic [8:0]          word_cnt_reg;
  logic                ack_d_reg;
  logic                pk_valid;
  logic [31:0]         pk_word;
  logic                last_word;
  logic                host_style;

  assign last_word  = (word_cnt_reg == 9'(bms_pkg::BOOT_WORDS - 1));
  assign host_style = (o_straps.mode == bms_pkg::MODE_HOST) ||
                      (o_straps.mode == bms_pkg::MODE_EMU);

  ////////////////////////////////////////////////////////////////////////////
  // Straps are caught by a clocked edge after release, never by the reset.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_straps     <= '0;
      o_int_resetn <= 1'b0;
    end else if (!o_int_resetn) begin
      o_straps     <= {i_boot_mode, i_rom_width, i_big_endian};
      o_int_resetn <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot state machine.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg        <= bms_pkg::ST_RESET;
      o_cpu_stall      <= 1'b1;
      o_cpu_start      <= 1'b0;
      o_cpu_start_addr <= bms_pkg::CPU_START_ADDR;
      o_host_mem_en    <= 1'b0;
    end else begin
      o_cpu_start <= 1'b0;
      unique case (state_reg)
        bms_pkg::ST_RESET: begin
          if (o_int_resetn) begin
            o_host_mem_en <= 1'b1;
            // Unused mode codes copy the ROM, so no stray strap can hang.
            if (!host_style) begin
              state_reg <= bms_pkg::ST_COPY_RD;
            end else begin
              state_reg <= bms_pkg::ST_HOST_WAIT;
            end
          end
        end
        bms_pkg::ST_HOST_WAIT: begin
          // A bit already set by the emulator releases just the same.
          if (o_hostint_bit && host_style) begin
            state_reg        <= bms_pkg::ST_RUN;
            o_cpu_stall      <= 1'b0;
            o_cpu_start      <= 1'b1;
            o_cpu_start_addr <= bms_pkg::CPU_START_ADDR;
          end
        end
        bms_pkg::ST_COPY_RD: begin
          if (pk_valid) begin
            state_reg <= bms_pkg::ST_COPY_WR;
          end
        end
        bms_pkg::ST_COPY_WR: begin
          if (i_mem_wr_ready) begin
            if (last_word) begin
              state_reg        <= bms_pkg::ST_RUN;
              o_cpu_stall      <= 1'b0;
              o_cpu_start      <= 1'b1;
              o_cpu_start_addr <= bms_pkg::CPU_START_ADDR;
            end else begin
              state_reg <= bms_pkg::ST_COPY_RD;
            end
          end
        end
        bms_pkg::ST_RUN: begin
          state_reg <= bms_pkg::ST_RUN;
        end
        default: begin
          state_reg <= bms_pkg::ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host interrupt bit: a set in the clearing cycle wins.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hostint_bit <= 1'b0;
      o_cpu_hostint <= 1'b0;
    end else begin
      if (i_hostint_set) begin
        o_hostint_bit <= 1'b1;
      end else if (i_hostint_clear) begin
        o_hostint_bit <= 1'b0;
      end
      // Only a fresh set while running reaches the CPU as an interrupt.
      o_cpu_hostint <= i_hostint_set && !o_hostint_bit &&
                       (state_reg == bms_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-frame block copy: one request at a time, never pipelined, so
  // the ROM side needs no flow control beyond its ack.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rom_rd     <= '0;
      o_mem_wr     <= '0;
      word_cnt_reg <= 9'h000;
      ack_d_reg    <= 1'b0;
    end else begin
      ack_d_reg <= o_rom_rd.req && i_rom_ack;
      if (o_rom_rd.req && i_rom_ack) begin
        o_rom_rd.req  <= 1'b0;
        o_rom_rd.addr <= o_rom_rd.addr +
                         32'(bms_pkg::bms_lane_bytes(o_straps.width));
      end else if (state_reg == bms_pkg::ST_RESET) begin
        o_rom_rd.addr <= ROM_BASE;
      end else if (state_reg == bms_pkg::ST_COPY_RD && !o_rom_rd.req &&
                   !ack_d_reg && !pk_valid) begin
        o_rom_rd.req <= 1'b1;
      end
      if (state_reg == bms_pkg::ST_COPY_RD && pk_valid) begin
        o_mem_wr.valid <= 1'b1;
        o_mem_wr.data  <= pk_word;
        o_mem_wr.addr  <= bms_pkg::BOOT_DEST_ADDR +
                          {21'h00_0000, word_cnt_reg, 2'h0};
      end else if (o_mem_wr.valid && i_mem_wr_ready) begin
        o_mem_wr.valid <= 1'b0;
        word_cnt_reg   <= word_cnt_reg + 9'h001;
      end
    end
  end

  bms_word_packer u_packer (
    .i_clk_sys    (i_clk_sys),
    .i_resetn     (i_resetn),
    .i_width      (o_straps.width),
    .i_big_endian (o_straps.big_endian),
    .i_valid      (o_rom_rd.req && i_rom_ack),
    .i_data       (i_rom_data),
    .o_word_valid (pk_valid),
    .o_word       (pk_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_int_reset_one: assert property (
    $rose(o_int_resetn) |-> o_cpu_stall && !o_host_mem_en &&
      state_reg == bms_pkg::ST_RESET)
    else $error("internal reset left out of order");
  a_straps_held: assert property (
    o_int_resetn && $past(o_int_resetn) |-> $stable(o_straps))
    else $error("boot straps changed after capture");
  a_host_mem_stall: assert property (
    o_int_resetn && state_reg == bms_pkg::ST_HOST_WAIT
      |-> o_cpu_stall && o_host_mem_en)
    else $error("host stall without host access");
  a_host_release: assert property (
    state_reg == bms_pkg::ST_HOST_WAIT && o_hostint_bit
      |=> o_cpu_start && !o_cpu_stall && o_cpu_start_addr == 32'h0000_0000)
    else $error("host release did not start the CPU at zero");
  a_no_pend_stall: assert property (
    o_cpu_hostint |-> $past(state_reg) == bms_pkg::ST_RUN)
    else $error("stall release interrupt reached the CPU");
  a_external_memory_interface_no_release: assert property (
    !host_style && state_reg != bms_pkg::ST_RUN
      && state_reg != bms_pkg::ST_COPY_WR |=> o_cpu_stall)
    else $error("interrupt bit released a ROM boot");
  a_bit_blocks_int: assert property (
    o_hostint_bit && i_hostint_set |=> !o_cpu_hostint)
    else $error("interrupt accepted while bit set");
  a_copy_count: assert property (
    o_cpu_start && !host_style
      |-> word_cnt_reg == 9'(bms_pkg::BOOT_WORDS))
    else $error("boot copy length wrong");
  a_copy_then_run: assert property (
    state_reg == bms_pkg::ST_COPY_WR && i_mem_wr_ready && last_word
      |=> o_cpu_start ##1 !o_cpu_start && !o_cpu_stall)
    else $error("CPU not released after copy");
  a_wr_addr_seq: assert property (
    $rose(o_mem_wr.valid) |-> o_mem_wr.addr[1:0] == 2'h0 &&
      o_mem_wr.addr[31:2] == {21'h00_0000, word_cnt_reg})
    else $error("boot write address out of sequence");

  c_host_boot: cover property (
    state_reg == bms_pkg::ST_HOST_WAIT ##1 o_cpu_start);
  c_external_memory_interface_boot: cover property (
    o_straps.mode == bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE && o_cpu_start);
  c_rom_8bit: cover property (
    o_straps.width == bms_pkg::WIDTH_8 && pk_valid);
  c_run_int: cover property (o_cpu_hostint);

endmodule

// [verif/bms_rom_model.sv]
/*
 * Far-side model of the boot sequencer: boot ROM and memory write port.
 * Assumes the bench gives it the board's ROM width and byte order.
 */
`timescale 1ns/100ps
module bms_rom_model (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic                  i_slow,
  input  wire logic [1:0]            i_width,
  input  wire logic                  i_big_endian,
  input  wire bms_pkg::bms_rom_req_s i_rom_rd,
  input  wire bms_pkg::bms_mem_wr_s  i_mem_wr,
  output logic                       o_rom_ack,
  output logic [31:0]                o_rom_data,
  output logic                       o_mem_wr_ready
);
  logic [31:0] mem [0:255];
  int          wr_count;
  int          bad_addr;
  int          wait_cnt;
  logic        served;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rom_byte(input logic [31:0] a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction

  // Image is stored in the byte order the system runs in.
  function automatic logic [31:0] rom_read(input logic [31:0] a);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = rom_byte(a);
    b1 = rom_byte(a + 32'h1);
    if (i_width == bms_pkg::WIDTH_8) begin
      return {~a[23:0], b0};
    end else if (i_width == bms_pkg::WIDTH_16) begin
      return i_big_endian ? {~a[15:0], b0, b1} : {~a[15:0], b1, b0};
    end
    return i_big_endian ? {b0, b1, rom_byte(a + 32'h2), rom_byte(a + 32'h3)}
                        : {rom_byte(a + 32'h3), rom_byte(a + 32'h2), b1, b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Idle data lines toggle so a late sample never looks like valid data.
  always @(negedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rom_ack      <= 1'b0;
      o_rom_data     <= 32'h0;
      o_mem_wr_ready <= 1'b0;
      served         <= 1'b0;
      wait_cnt       <= 0;
    end else begin
      o_mem_wr_ready <= i_slow ? ~o_mem_wr_ready : 1'b1;
      if (o_rom_ack) begin
        o_rom_ack  <= 1'b0;
        o_rom_data <= ~o_rom_data;
        served     <= 1'b1;
      end else if (i_rom_rd.req && !served &&
                   wait_cnt >= (i_slow ? 3 : 0)) begin
        o_rom_ack  <= 1'b1;
        o_rom_data <= rom_read(i_rom_rd.addr);
        wait_cnt   <= 0;
      end else begin
        o_rom_data <= ~o_rom_data;
        if (i_rom_rd.req && !served) begin
          wait_cnt <= wait_cnt + 1;
        end
        if (!i_rom_rd.req) begin
          served <= 1'b0;
        end
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wr_count <= 0;
      bad_addr <= 0;
      foreach (mem[i]) mem[i] <= 32'hffff_ffff;
    end else if (i_mem_wr.valid && o_mem_wr_ready) begin
      wr_count <= wr_count + 1;
      if (i_mem_wr.addr >= 32'h400 || i_mem_wr.addr[1:0] != 2'h0) begin
        bad_addr <= bad_addr + 1;
      end else begin
        mem[i_mem_wr.addr[9:2]] <= i_mem_wr.data;
      end
    end
  end
endmodule

// [verif/boot_mode_sequencer_tb.sv]
/*
 * Self-checking bench of the boot sequencer: reset, host, emulation and
 * ROM boot in every ROM width and both byte orders.
 * Assumes the far-side model in bms_rom_model.
 */
`timescale 1ns/100ps
module boot_mode_sequencer_tb;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic [1:0]            boot_mode = 2'h0;
  logic [1:0]            rom_width = 2'h0;
  logic                  big_endian = 1'b0;
  logic                  hostint_set = 1'b0;
  logic                  hostint_clear = 1'b0;
  logic                  slow = 1'b0;
  logic                  rom_ack;
  logic [31:0]           rom_data;
  logic                  mem_ready;
  logic                  o_int_resetn;
  logic                  o_cpu_stall;
  logic                  o_cpu_start;
  logic [31:0]           o_cpu_start_addr;
  logic                  o_host_mem_en;
  logic                  o_hostint_bit;
  logic                  o_cpu_hostint;
  bms_pkg::bms_straps_s  straps;
  bms_pkg::bms_rom_req_s rom_rd;
  bms_pkg::bms_mem_wr_s  mem_wr;
  int                    bad_count = 0;
  int                    comparisons = 0;
  int                    starts_seen = 0;
  int                    ints_seen = 0;
  int                    wr_at_start = 0;

  always #2 clk = ~clk;

  bms_boot_sequencer u_bms_boot_sequencer (
    .i_clk_sys(clk), .i_resetn(resetn), .i_boot_mode(boot_mode),
    .i_rom_width(rom_width), .i_big_endian(big_endian),
    .i_hostint_set(hostint_set), .i_hostint_clear(hostint_clear),
    .i_rom_ack(rom_ack), .i_rom_data(rom_data), .i_mem_wr_ready(mem_ready),
    .o_int_resetn(o_int_resetn), .o_cpu_stall(o_cpu_stall),
    .o_cpu_start(o_cpu_start), .o_cpu_start_addr(o_cpu_start_addr),
    .o_host_mem_en(o_host_mem_en), .o_hostint_bit(o_hostint_bit),
    .o_cpu_hostint(o_cpu_hostint), .o_straps(straps), .o_rom_rd(rom_rd),
    .o_mem_wr(mem_wr));

  bms_rom_model u_bms_rom_model (
    .i_clk_sys(clk), .i_resetn(resetn), .i_slow(slow), .i_width(rom_width),
    .i_big_endian(big_endian), .i_rom_rd(rom_rd), .i_mem_wr(mem_wr),
    .o_rom_ack(rom_ack), .o_rom_data(rom_data), .o_mem_wr_ready(mem_ready));

  always @(posedge clk) begin
    if (o_cpu_start === 1'b1) begin
      starts_seen++;
      wr_at_start = u_bms_rom_model.wr_count;
    end
    if (o_cpu_hostint === 1'b1) begin
      ints_seen++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] exp_word(input int w, input logic be);
    logic [9:0] a;
    logic [7:0] b [4];
    for (int i = 0; i < 4; i++) begin
      a = 10'(w * 4 + i);
      b[i] = a[7:0] ^ {a[9:8], 6'h15};
    end
    return be ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]};
  endfunction

  // The clock runs all through reset, so release meets a steady clock.
  task automatic do_reset(input logic [1:0] mode, input logic [1:0] width,
                          input logic be);
    @(negedge clk);
    resetn = 1'b0;
    boot_mode = mode;
    rom_width = width;
    big_endian = be;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    starts_seen = 0;
    ints_seen = 0;
  endtask

  task automatic pulse_set();
    hostint_set = 1'b1;
    @(negedge clk);
    hostint_set = 1'b0;
  endtask

  task automatic wait_start(input int limit);
    int n;
    n = 0;
    while (starts_seen == 0 && n < limit) begin
      @(negedge clk);
      n++;
    end
    check("cpu_start_count", 1, starts_seen);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_mid_copy();
    slow = 1'b1;
    do_reset(bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE, bms_pkg::WIDTH_8, 1'b0);
    pulse_set();
    repeat (100) @(negedge clk);
    resetn = 1'b0;
    #1;
    check("rst_int_resetn", 0, o_int_resetn);
    check("rst_stall", 1, o_cpu_stall);
    check("rst_bit", 0, o_hostint_bit);
    check("rst_rom_req", 0, rom_rd.req);
    check("rst_wr_valid", 0, mem_wr.valid);
    check("rst_host_mem", 0, o_host_mem_en);
  endtask

  task automatic host_boot();
    do_reset(bms_pkg::MODE_HOST, bms_pkg::WIDTH_32, 1'b0);
    repeat (3) @(negedge clk);
    boot_mode = bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE;
    check("int_resetn", 1, o_int_resetn);
    check("host_mem_en", 1, o_host_mem_en);
    repeat (20) @(negedge clk);
    check("strap_mode", bms_pkg::MODE_HOST, straps.mode);
    check("host_stall", 1, o_cpu_stall);
    check("host_rom_req", 0, rom_rd.req);
    pulse_set();
    wait_start(8);
    check("host_run", 0, o_cpu_stall);
    check("start_addr", 0, o_cpu_start_addr);
    check("boot_int", 0, ints_seen);
    pulse_set();
    repeat (3) @(negedge clk);
    check("int_refused", 0, ints_seen);
    hostint_clear = 1'b1;
    @(negedge clk);
    hostint_clear = 1'b0;
    @(negedge clk);
    check("bit_cleared", 0, o_hostint_bit);
    pulse_set();
    repeat (3) @(negedge clk);
    check("int_taken", 1, ints_seen);
  endtask

  // Breakpoint placement is the emulator's own job, unseen here.
  task automatic emu_boot();
    do_reset(bms_pkg::MODE_EMU, bms_pkg::WIDTH_16, 1'b1);
    repeat (10) @(negedge clk);
    check("emu_stall", 1, o_cpu_stall);
    pulse_set();
    wait_start(8);
    check("emu_run", 0, o_cpu_stall);
    check("emu_int", 0, ints_seen);
  endtask

  task automatic rom_boot(input logic [1:0] mode, input logic [1:0] width,
                          input logic be, input logic s);
    slow = s;
    do_reset(mode, width, be);
    repeat (4) @(negedge clk);
    pulse_set();
    repeat (20) @(negedge clk);
    check("rom_stall", 1, o_cpu_stall);
    check("rom_early", 0, starts_seen);
    wait_start(30000);
    check("wr_at_start", 256, wr_at_start);
    check("bad_addr", 0, u_bms_rom_model.bad_addr);
    for (int w = 0; w < 256; w++) begin
      check("boot_word", exp_word(w, be), u_bms_rom_model.mem[w]);
    end
    check("rom_run", 0, o_cpu_stall);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Longest path is the slow byte-wide copy; the limit leaves ample margin.
  initial begin
    #(60000 * 4);
    bad_count++;
    print_verdict();
  end

  initial begin
    reset_mid_copy();
    host_boot();
    emu_boot();
    rom_boot(bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE, bms_pkg::WIDTH_32, 1'b0, 1'b0);
    rom_boot(bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE, bms_pkg::WIDTH_16, 1'b1, 1'b1);
    rom_boot(bms_pkg::MODE_EXTERNAL_MEMORY_INTERFACE, bms_pkg::WIDTH_8, 1'b0, 1'b1);
    rom_boot(2'h3, bms_pkg::WIDTH_8, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
